/* File: src/osc_consts.svh */
// offsets, field positions, reset values and timing counts of the oscillator control block
`ifndef OSC_CONSTS_SVH
`define OSC_CONSTS_SVH

// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define OSC_OFF_MAIN_CLOCK_CONTROL 8'h00
`define OSC_OFF_CLOCK_SELECT       8'h04
`define OSC_OFF_OSC0_CONTROL       8'h08
`define OSC_OFF_OSC1_CONTROL       8'h0C
`define OSC_OFF_RC_CALIBRATION     8'h10
`define OSC_OFF_POWER_STATUS       8'h14
`define OSC_OFF_IRQ_STATUS         8'h18
`define OSC_OFF_IRQ_MASK           8'h1C

// ****************************************************************
// field positions
// ****************************************************************
`define OSC_MCC_SEL_LSB    0
`define OSC_MCC_SEL_MSB    1
`define OSC_MCC_EN0_BIT    2
`define OSC_MCC_EN1_BIT    3
`define OSC_CTL_MODE_BIT   0
`define OSC_CTL_START_LSB  8
`define OSC_CTL_START_MSB  10
`define OSC_CKS_CPU_LSB    0
`define OSC_CKS_HSB_LSB    8
`define OSC_CKS_PBA_LSB    16
`define OSC_CKS_PBB_LSB    24
`define OSC_RC_CAL_W       10
`define OSC_STAT_RC_BIT    2

// ****************************************************************
// reset values
// ****************************************************************
`define OSC_RST_MCSEL      2'h0
`define OSC_RST_CLOCK_SELECT_REGISTER      8'h00
`define OSC_RST_OSC_CTL    4'h0
`define OSC_RST_IRQ_MASK   2'h0

// ****************************************************************
// timing
// ****************************************************************
`define OSC_PCLK_HZ        40000000
`define OSC_RC_HZ          115000
`define OSC_RC_DIV         (`OSC_PCLK_HZ / `OSC_RC_HZ)
`define OSC_RC_STARTUP_CYC 3
`define OSC_START_CNT_W    16

`endif

/* File: src/osc_pkg.sv */
// types shared by the oscillator control block
package osc_pkg;

  typedef enum logic [2:0] {
    OSC_SLP_IDLE,
    OSC_SLP_FROZEN,
    OSC_SLP_STANDBY,
    OSC_SLP_STOP,
    OSC_SLP_DEEPSTOP,
    OSC_SLP_STATIC
  } osc_sleep_e;

  typedef enum logic {
    OSC_ST_RUN,
    OSC_ST_SLEEP
  } osc_pwr_e;

  // one synchronous domain divider setting
  typedef struct packed {
    logic       div_en;
    logic [2:0] div_sel;
  } osc_div_s;

  typedef struct packed {
    osc_div_s cpu_hsb;
    osc_div_s peripheral_bus_a;
    osc_div_s peripheral_bus_b;
  } osc_clkdiv_s;

  // pad control of one main oscillator
  typedef struct packed {
    logic enable;
    logic ext_mode;
  } osc_pad_s;

  // slow ticks of start-up for a select code; 0 means no wait
  function automatic logic [15:0] osc_startup_ticks(input logic [2:0] sel);
    // shift amount widened so that sel + 5 cannot wrap in three bits
    osc_startup_ticks = (sel == 3'h0) ? 16'h0000 : (16'h0001 << ({1'b0, sel} + 4'h5));
  endfunction

endpackage

/* File: src/osc_slow_clock_control.sv */
// oscillator and slow clock control with APB register slave
//
// The address map and the APB register port were chosen for this implementation.
`include "osc_consts.svh"
`timescale 1ns/100ps
module osc_slow_clock_control
  import osc_pkg::*;
#(
  parameter int RC_DIV = `OSC_RC_DIV
) (
  // clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // apb slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // pins
  input  wire logic [1:0]               osc_xin,
  input  wire logic [`OSC_RC_CAL_W-1:0] rc_calibration_fuses,
  // processor sleep and wake
  input  wire logic                     sleep_req,
  input  wire logic [2:0]               sleep_mode,
  input  wire logic                     wake_irq,
  // slow clock
  output logic                          rc_run,
  output logic [`OSC_RC_CAL_W-1:0]      rc_cal,
  output logic                          rc_ready,
  output logic                          slow_tick,
  output logic                          wdt_tick,
  // main oscillators
  output osc_pad_s                      osc0_pad,
  output osc_pad_s                      osc1_pad,
  output logic [1:0]                    osc_clk_out,
  output logic [1:0]                    osc_ready_flag,
  output logic [1:0]                    generic_src_ok,
  // synchronous clock setup
  output logic [1:0]                    main_clk_sel,
  output osc_clkdiv_s                   clk_div,
  output logic                          sleeping,
  // interrupt
  output logic                          pm_irq
);

  // ****************************************************************
  // parameter check
  // ****************************************************************
  if (RC_DIV < 2 || RC_DIV > 65535) begin : g_bad_div
    $error("RC_DIV out of range");
  end

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [1:0]               xin_s;
  logic [`OSC_RC_CAL_W-1:0] fuse_s;

  osc_sync #(.WIDTH(2)) u_sync_xin (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (osc_xin),
    .sync_out (xin_s)
  );

  osc_sync #(.WIDTH(`OSC_RC_CAL_W)) u_sync_fuse (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (rc_calibration_fuses),
    .sync_out (fuse_s)
  );

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [1:0]               mcsel_q, mcsel_d;
  logic [1:0]               osc_en_q, osc_en_d;
  logic [3:0]               osc_ctl0_q, osc_ctl0_d;
  logic [3:0]               osc_ctl1_q, osc_ctl1_d;
  osc_clkdiv_s              ckdiv_q, ckdiv_d;
  logic [`OSC_RC_CAL_W-1:0] rccal_q, rccal_d;
  logic [1:0]               cal_ld_q, cal_ld_d;
  logic [1:0]               isr_q, isr_d;
  logic [1:0]               imr_q, imr_d;
  logic [1:0]               rdy_prev_q, rdy_prev_d;
  logic [31:0]              rdata_q, rdata_d;
  logic                     err_q, err_d;

  logic                     wr_acc;
  logic                     rd_acc;
  logic                     addr_ok;
  logic [1:0]               rdy;
  logic [1:0]               rdy_rise;

  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && penable && !pwrite;

  function automatic logic osc_addr_hit(input logic [7:0] a);
    case (a)
      `OSC_OFF_MAIN_CLOCK_CONTROL,
      `OSC_OFF_CLOCK_SELECT,
      `OSC_OFF_OSC0_CONTROL,
      `OSC_OFF_OSC1_CONTROL,
      `OSC_OFF_RC_CALIBRATION,
      `OSC_OFF_POWER_STATUS,
      `OSC_OFF_IRQ_STATUS,
      `OSC_OFF_IRQ_MASK: osc_addr_hit = 1'b1;
      default:           osc_addr_hit = 1'b0;
    endcase
  endfunction

  function automatic osc_div_s osc_div_field(input logic [31:0] w, input int lsb);
    osc_div_field.div_sel = w[lsb +: 3];
    osc_div_field.div_en  = w[lsb + 7];
  endfunction

  function automatic logic [7:0] osc_div_pack(input osc_div_s d);
    osc_div_pack = {d.div_en, 4'h0, d.div_sel};
  endfunction

  assign addr_ok = osc_addr_hit(paddr);

  // ****************************************************************
  // register writes, read data and interrupt status
  // ****************************************************************
  always_comb begin
    mcsel_d    = mcsel_q;
    osc_en_d   = osc_en_q;
    osc_ctl0_d = osc_ctl0_q;
    osc_ctl1_d = osc_ctl1_q;
    ckdiv_d    = ckdiv_q;
    rccal_d    = rccal_q;
    cal_ld_d   = (cal_ld_q == 2'h3) ? cal_ld_q : cal_ld_q + 2'h1;
    imr_d      = imr_q;
    rdy_prev_d = rdy;
    rdata_d    = rdata_q;
    err_d      = 1'b0;
    // fuses settle through the synchroniser before they are taken
    if (cal_ld_q == 2'h2) begin
      rccal_d = fuse_s;
    end
    if (wr_acc && addr_ok) begin
      case (paddr)
        `OSC_OFF_MAIN_CLOCK_CONTROL: begin
          // only slow clock or oscillator 0 feed the main clock
          if (pwdata[`OSC_MCC_SEL_MSB:`OSC_MCC_SEL_LSB] <= 2'h1) begin
            mcsel_d = pwdata[`OSC_MCC_SEL_MSB:`OSC_MCC_SEL_LSB];
          end
          osc_en_d = {pwdata[`OSC_MCC_EN1_BIT], pwdata[`OSC_MCC_EN0_BIT]};
        end
        `OSC_OFF_CLOCK_SELECT: begin
          ckdiv_d.cpu_hsb = osc_div_field(pwdata, `OSC_CKS_CPU_LSB);
          ckdiv_d.peripheral_bus_a     = osc_div_field(pwdata, `OSC_CKS_PBA_LSB);
          ckdiv_d.peripheral_bus_b     = osc_div_field(pwdata, `OSC_CKS_PBB_LSB);
        end
        `OSC_OFF_OSC0_CONTROL: begin
          osc_ctl0_d = {pwdata[`OSC_CTL_START_MSB:`OSC_CTL_START_LSB],
                        pwdata[`OSC_CTL_MODE_BIT]};
        end
        `OSC_OFF_OSC1_CONTROL: begin
          osc_ctl1_d = {pwdata[`OSC_CTL_START_MSB:`OSC_CTL_START_LSB],
                        pwdata[`OSC_CTL_MODE_BIT]};
        end
        `OSC_OFF_RC_CALIBRATION: begin
          rccal_d = pwdata[`OSC_RC_CAL_W-1:0];
        end
        `OSC_OFF_IRQ_MASK: begin
          imr_d = pwdata[1:0];
        end
        default: begin
          rdata_d = rdata_q;
        end
      endcase
    end
    if (psel && !penable) begin
      rdata_d = 32'h0000_0000;
      err_d   = !addr_ok;
      case (paddr)
        `OSC_OFF_MAIN_CLOCK_CONTROL: rdata_d = {28'h0, osc_en_q, mcsel_q};
        `OSC_OFF_CLOCK_SELECT: begin
          rdata_d = {osc_div_pack(ckdiv_q.peripheral_bus_b), osc_div_pack(ckdiv_q.peripheral_bus_a),
                     osc_div_pack(ckdiv_q.cpu_hsb),
                     osc_div_pack(ckdiv_q.cpu_hsb)};
        end
        `OSC_OFF_OSC0_CONTROL: rdata_d = {21'h0, osc_ctl0_q[3:1], 7'h0, osc_ctl0_q[0]};
        `OSC_OFF_OSC1_CONTROL: rdata_d = {21'h0, osc_ctl1_q[3:1], 7'h0, osc_ctl1_q[0]};
        `OSC_OFF_RC_CALIBRATION: rdata_d = {22'h0, rccal_q};
        `OSC_OFF_POWER_STATUS: rdata_d = {29'h0, rc_ready, rdy};
        // an event in the setup cycle is shown, since the access clears it
        `OSC_OFF_IRQ_STATUS: rdata_d = {30'h0, isr_q | rdy_rise};
        `OSC_OFF_IRQ_MASK: rdata_d = {30'h0, imr_q};
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // sticky ready events; a new event beats the read clear
  // ****************************************************************
  assign rdy_rise = rdy & ~rdy_prev_q;

  always_comb begin
    isr_d = isr_q;
    if (rd_acc && paddr == `OSC_OFF_IRQ_STATUS) begin
      isr_d = 2'h0;
    end
    isr_d = isr_d | rdy_rise;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcsel_q    <= `OSC_RST_MCSEL;
      osc_en_q   <= 2'h0;
      osc_ctl0_q <= `OSC_RST_OSC_CTL;
      osc_ctl1_q <= `OSC_RST_OSC_CTL;
      ckdiv_q    <= '0;
      rccal_q    <= '0;
      cal_ld_q   <= 2'h0;
      isr_q      <= 2'h0;
      imr_q      <= `OSC_RST_IRQ_MASK;
      rdy_prev_q <= 2'h0;
      rdata_q    <= 32'h0000_0000;
      err_q      <= 1'b0;
    end else begin
      mcsel_q    <= mcsel_d;
      osc_en_q   <= osc_en_d;
      osc_ctl0_q <= osc_ctl0_d;
      osc_ctl1_q <= osc_ctl1_d;
      ckdiv_q    <= ckdiv_d;
      rccal_q    <= rccal_d;
      cal_ld_q   <= cal_ld_d;
      isr_q      <= isr_d;
      imr_q      <= imr_d;
      rdy_prev_q <= rdy_prev_d;
      rdata_q    <= rdata_d;
      err_q      <= err_d;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = rdata_q;
  assign pslverr = psel && penable && err_q;
  assign pm_irq  = |(isr_q & imr_q);

  // ****************************************************************
  // sleep control
  // ****************************************************************
  osc_pwr_e   pwr_q, pwr_d;
  osc_sleep_e smode_q, smode_d;
  logic       osc_stop;

  always_comb begin
    pwr_d   = pwr_q;
    smode_d = smode_q;
    case (pwr_q)
      OSC_ST_RUN: begin
        if (sleep_req && sleep_mode <= 3'(OSC_SLP_STATIC)) begin
          pwr_d   = OSC_ST_SLEEP;
          smode_d = osc_sleep_e'(sleep_mode);
        end
      end
      OSC_ST_SLEEP: begin
        if (wake_irq || pm_irq) begin
          pwr_d = OSC_ST_RUN;
        end
      end
      default: pwr_d = OSC_ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_q   <= OSC_ST_RUN;
      smode_q <= OSC_SLP_IDLE;
    end else begin
      pwr_q   <= pwr_d;
      smode_q <= smode_d;
    end
  end

  // stop and deeper modes take the crystals down
  assign osc_stop = (pwr_q == OSC_ST_SLEEP) && (smode_q >= OSC_SLP_STOP);
  assign rc_run   = !((pwr_q == OSC_ST_SLEEP) && (smode_q == OSC_SLP_STATIC));
  assign sleeping = (pwr_q == OSC_ST_SLEEP);

  // ****************************************************************
  // RC slow clock: divider and short start-up
  // ****************************************************************
  logic [15:0] div_q, div_d;
  logic [1:0]  rcst_q, rcst_d;
  logic        tick_q, tick_d;

  always_comb begin
    div_d  = div_q;
    rcst_d = rcst_q;
    tick_d = 1'b0;
    if (!rc_run) begin
      div_d  = 16'h0000;
      rcst_d = 2'h0;
    end else if (div_q == 16'(RC_DIV - 1)) begin
      div_d  = 16'h0000;
      tick_d = 1'b1;
      if (rcst_q != 2'(`OSC_RC_STARTUP_CYC)) begin
        rcst_d = rcst_q + 2'h1;
      end
    end else begin
      div_d = div_q + 16'h0001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= 16'h0000;
      rcst_q <= 2'h0;
      tick_q <= 1'b0;
    end else begin
      div_q  <= div_d;
      rcst_q <= rcst_d;
      tick_q <= tick_d;
    end
  end

  assign rc_ready  = rc_run && (rcst_q == 2'(`OSC_RC_STARTUP_CYC));
  assign slow_tick = tick_q && rc_ready;
  assign wdt_tick  = slow_tick;
  assign rc_cal    = rccal_q;

  // ****************************************************************
  // main oscillators
  // ****************************************************************
  logic [1:0] powered;
  logic [1:0] clk_q, clk_d;

  assign powered = osc_en_q & {2{!osc_stop}};

  osc_startup u_start0 (
    .pclk      (pclk),
    .presetn   (presetn),
    .slow_tick (slow_tick),
    .powered   (powered[0]),
    .start_sel (osc_ctl0_q[3:1]),
    .ready     (rdy[0])
  );

  osc_startup u_start1 (
    .pclk      (pclk),
    .presetn   (presetn),
    .slow_tick (slow_tick),
    .powered   (powered[1]),
    .start_sel (osc_ctl1_q[3:1]),
    .ready     (rdy[1])
  );

  always_comb begin
    clk_d = xin_s & rdy;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= 2'h0;
    end else begin
      clk_q <= clk_d;
    end
  end

  assign osc0_pad.enable   = powered[0];
  assign osc0_pad.ext_mode = osc_ctl0_q[0];
  assign osc1_pad.enable   = powered[1];
  assign osc1_pad.ext_mode = osc_ctl1_q[0];
  assign osc_clk_out       = clk_q;
  assign osc_ready_flag    = rdy;
  assign generic_src_ok    = rdy;
  // oscillator 0 is only offered to the main clock once it is ready
  assign main_clk_sel      = (mcsel_q == 2'h1 && !rdy[0]) ? 2'h0 : mcsel_q;
  assign clk_div           = ckdiv_q;

endmodule

/* File: src/osc_startup.sv */
// start-up timer and ready flag of one main oscillator
`include "osc_consts.svh"
`timescale 1ns/100ps
module osc_startup
  import osc_pkg::*;
(
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic       slow_tick,
  input  wire logic       powered,
  input  wire logic [2:0] start_sel,
  // status
  output logic            ready
);

  logic [`OSC_START_CNT_W-1:0] cnt_q, cnt_d;
  logic                        pwr_q, pwr_d;
  logic                        rdy_q, rdy_d;

  always_comb begin
    pwr_d = powered;
    cnt_d = cnt_q;
    rdy_d = rdy_q;
    if (!powered) begin
      cnt_d = '0;
      rdy_d = 1'b0;
    end else if (!pwr_q) begin
      cnt_d = '0;
      rdy_d = 1'b0;
    end else if (!rdy_q) begin
      // start-up is timed in slow clock periods
      if (cnt_q >= osc_startup_ticks(start_sel)) begin
        rdy_d = 1'b1;
      end else if (slow_tick) begin
        cnt_d = cnt_q + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      pwr_q <= 1'b0;
      rdy_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      pwr_q <= pwr_d;
      rdy_q <= rdy_d;
    end
  end

  assign ready = rdy_q;

endmodule

/* File: src/osc_sync.sv */
// two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps
module osc_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  // data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

/* File: test/osc_slow_clock_control_properties.sv */
// checker of the oscillator control block, bound to its top module
`timescale 1ns/100ps
module osc_props
  import osc_pkg::*;
#(
  parameter int RC_DIV = 347
) (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // apb
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pslverr,
  // sleep
  input wire logic       sleeping,
  input wire logic       wake_irq,
  // clocks
  input wire logic       rc_run,
  input wire logic       rc_ready,
  input wire logic       slow_tick,
  input wire logic       wdt_tick,
  input wire osc_pad_s   osc0_pad,
  input wire logic [1:0] osc_clk_out,
  input wire logic [1:0] osc_ready_flag,
  input wire logic [1:0] generic_src_ok,
  input wire logic [1:0] main_clk_sel
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************************************
  // properties
  // ****************************************************************
  // holds only while RC_DIV is at least 4
  sequence quiet3;
    !slow_tick [*3];
  endsequence
  rc_on_a: assert property (!sleeping |-> rc_run) else $error("rc stopped out of sleep");
  rc_rdy_a: assert property (rc_ready |-> rc_run) else $error("rc ready while stopped");
  wdt_tick_a: assert property (wdt_tick == slow_tick) else $error("watchdog tick differs");
  tick_gap_a: assert property (slow_tick |=> quiet3) else $error("slow ticks too close");
  out_mask_a: assert property (osc_clk_out[0] |-> osc_ready_flag[0] || $past(osc_ready_flag[0]))
    else $error("clock passed before ready");
  rise_en_a: assert property ($rose(osc_ready_flag[0]) |-> osc0_pad.enable)
    else $error("ready rose while off");
  off_clear_a: assert property (!osc0_pad.enable |=> !osc_ready_flag[0])
    else $error("ready kept while off");
  src_ok_a: assert property (generic_src_ok == osc_ready_flag) else $error("generic source");
  main_sel_a: assert property (main_clk_sel == 2'h1 |-> osc_ready_flag[0] || $past(osc_ready_flag[0]))
    else $error("main clock on unready osc");
  wake_exit_a: assert property (sleeping && wake_irq |=> !sleeping) else $error("no wake");
  err_phase_a: assert property (pslverr |-> psel && penable) else $error("stray slave error");
endmodule
bind osc_slow_clock_control osc_props #(.RC_DIV(RC_DIV)) u_osc_props (.*);

/* File: test/osc_xtal_model.sv */
// behavioural crystal pair at the oscillator pads
`timescale 1ns/100ps
module osc_xtal_model
  import osc_pkg::*;
(
  // clock
  input  wire logic     pclk,
  // pad control
  input  wire osc_pad_s osc0_pad,
  input  wire osc_pad_s osc1_pad,
  // pad levels
  output logic [1:0]    xin
);
  initial xin = 2'h0;
  // released pad sits at its weak pull-down
  always @(posedge pclk) begin
    xin[0] <= osc0_pad.enable ? ~xin[0] : 1'b0;
    xin[1] <= osc1_pad.enable ? ~xin[1] : 1'b0;
  end
endmodule

/* File: test/tb_top.sv */
// self-checking testbench of the oscillator control block
`timescale 1ns/100ps
module tb_top;
  import osc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, sleep_req, wake_irq, pready, pslverr;
  logic        rc_run, rc_ready, slow_tick, sleeping, pm_irq, last_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [2:0]  sleep_mode;
  logic [9:0]  rc_cal;
  logic [1:0]  xin, osc_clk_out, osc_ready_flag, main_clk_sel;
  osc_pad_s    osc0_pad, osc1_pad;
  osc_clkdiv_s clk_div;
  int          errors, samples_checked, cyc, k;
  osc_slow_clock_control #(.RC_DIV(4)) u_osc_slow_clock_control (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .osc_xin(xin), .rc_calibration_fuses(10'h2A5), .sleep_req, .sleep_mode, .wake_irq,
    .rc_run, .rc_cal, .rc_ready, .slow_tick, .wdt_tick(), .osc0_pad, .osc1_pad, .osc_clk_out,
    .osc_ready_flag, .generic_src_ok(), .main_clk_sel, .clk_div, .sleeping, .pm_irq);
  osc_xtal_model u_osc_xtal_model (.pclk, .osc0_pad, .osc1_pad, .xin);
  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdv, exp);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask
  // counts high samples of one gated oscillator output
  task automatic hi_cnt(input int i, input int n);
    k = 0;
    repeat (n) begin
      wt(1);
      if (osc_clk_out[i] === 1'b1) k++;
    end
  endtask
  task automatic slp(input logic [2:0] m);
    @(posedge pclk);
    sleep_req <= 1'b1; sleep_mode <= m;
    @(posedge pclk);
    sleep_req <= 1'b0;
    wt(2);
  endtask
  task automatic wake();
    @(posedge pclk);
    wake_irq <= 1'b1;
    @(posedge pclk);
    wake_irq <= 1'b0;
    wt(1);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ****************************************************************
  // clock, timeout and tests
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, sleep_req, wake_irq} = 6'h0;
    paddr = 8'h00; pwdata = 32'h0; sleep_mode = 3'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    wt(20);
    check(osc0_pad, 2'h0);
    check(osc1_pad, 2'h0);
    check(rc_cal, 10'h2A5);
    check(rc_run, 1'b1);
    rd(8'h00, 32'h0);
    rd(8'h14, 32'h4);
    rd(8'h20, 32'h0);
    check(last_err, 1'b1);
    wr(8'h10, 32'h155);
    wt(1);
    check(rc_cal, 10'h155);
    $display("test reset_and_calibration done");
    wr(8'h1C, 32'h3);
    wr(8'h08, 32'h1);
    rd(8'h08, 32'h1);
    wr(8'h00, 32'h4);
    wt(1);
    check(osc0_pad, 2'h3);
    wt(4);
    rd(8'h14, 32'h5);
    check(pm_irq, 1'b1);
    rd(8'h18, 32'h1);
    wt(1);
    check(pm_irq, 1'b0);
    wr(8'h00, 32'h5);
    wt(2);
    check(main_clk_sel, 2'h1);
    hi_cnt(0, 8);
    check(k != 0, 1'b1);
    $display("test osc0_enable done");
    wr(8'h0C, 32'h100);
    wr(8'h00, 32'hD);
    hi_cnt(1, 200);
    check(k, 0);
    check(osc_ready_flag[1], 1'b0);
    check(osc1_pad, 2'h2);
    for (int n = 0; n < 100 && osc_ready_flag[1] !== 1'b1; n++) wt(1);
    check(osc_ready_flag[1], 1'b1);
    hi_cnt(1, 8);
    check(k != 0, 1'b1);
    rd(8'h18, 32'h2);
    wr(8'h00, 32'h5);
    wt(2);
    check(osc_ready_flag[1], 1'b0);
    wr(8'h00, 32'hD);
    wt(20);
    check(osc_ready_flag[1], 1'b0);
    wr(8'h00, 32'h5);
    $display("test osc1_startup done");
    wr(8'h04, 32'h0081_0583);
    rd(8'h04, 32'h0081_8383);
    check(clk_div.cpu_hsb, 4'hB);
    check(clk_div.peripheral_bus_a, 4'h9);
    check(clk_div.peripheral_bus_b, 4'h0);
    $display("test dividers done");
    slp(3'h3);
    check(sleeping, 1'b1);
    check(osc0_pad.enable, 1'b0);
    check(osc_ready_flag[0], 1'b0);
    check(main_clk_sel, 2'h0);
    check(rc_run, 1'b1);
    wake();
    check(sleeping, 1'b0);
    wt(4);
    check(osc_ready_flag[0], 1'b1);
    rd(8'h18, 32'h1);
    slp(3'h5);
    check(rc_run, 1'b0);
    check(rc_ready, 1'b0);
    wake();
    wt(20);
    check(rc_ready, 1'b1);
    $display("test sleep_wake done");
    print_verdict();
  end
endmodule
